// ---- src/dpsc_pkg.sv ----
package dpsc_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STEP_CMD = 8'h04;
    localparam logic [7:0] ADDR_DEV = 8'h08;
    localparam logic [7:0] ADDR_FBNUM_LO = 8'h0c;
    localparam logic [7:0] ADDR_FBNUM_HI = 8'h10;
    localparam logic [7:0] ADDR_HOFS_LO = 8'h14;
    localparam logic [7:0] ADDR_HOFS_HI = 8'h18;
    localparam logic [7:0] ADDR_APNUM_LO = 8'h1c;
    localparam logic [7:0] ADDR_APNUM_HI = 8'h20;
    localparam logic [7:0] ADDR_EFFFB_LO = 8'h24;
    localparam logic [7:0] ADDR_EFFFB_HI = 8'h28;
    localparam logic [7:0] ADDR_EFFAP_LO = 8'h2c;
    localparam logic [7:0] ADDR_EFFAP_HI = 8'h30;
    localparam logic [7:0] ADDR_STATUS = 8'h34;
    localparam logic [7:0] ADDR_RAMP = 8'h38;
    localparam logic [7:0] ADDR_DEV_LO = 8'h3c;

    // ==========================================================
    // Control register fields
    localparam int CTRL_HIST_EN = 0;
    localparam int CTRL_DCO_EN = 1;
    localparam int CTRL_PIN_EN = 2;
    localparam int CTRL_LOOP_EN = 3;
    localparam int CTRL_DEN_MODE = 4;
    localparam int CTRL_DIG_EN = 5;
    localparam int CTRL_W = 6;

    // Status register fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_FLL = 4;
    localparam int ST_PLL = 5;
    localparam int ST_HIST_VALID = 6;
    localparam int ST_RAMP_DONE = 7;
    localparam int ST_WIDE_BW = 8;
    localparam int ST_APLL_LOCK = 9;

    // ==========================================================
    // Widths and reset values
    localparam int NUM_W = 40;
    localparam int DEV_W = 38;
    localparam int RSTEP_W = 16;
    localparam int RPER_W = 16;
    localparam logic [NUM_W-1:0] FBNUM_RST = 40'h00_0000_0000;
    localparam logic [NUM_W-1:0] APNUM_RST = 40'h00_0000_0000;
    localparam logic [RSTEP_W-1:0] RSTEP_RST = 16'h0001;
    localparam logic [RPER_W-1:0] RPER_RST = 16'h0000;
    localparam logic [31:0] NOMAP_DATA = 32'h0000_0000;

    // ==========================================================
    // Timing: trigger pulses need >100 ns at the 10 ns clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int TRIG_MIN_NS = 100;
    localparam int TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Operating states, one-hot
    typedef enum logic [3:0] {
        DPSC_FREE_RUN = 4'b0001,
        DPSC_ACQUIRE = 4'b0010,
        DPSC_LOCKED = 4'b0100,
        DPSC_HOLDOVER = 4'b1000
    } dpsc_state_e;

endpackage

// ---- src/dpsc_ctrl.sv ----
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps

module dpsc_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic xo_valid,
    input wire logic ref_valid,
    input wire logic freq_locked,
    input wire logic phase_locked,
    input wire logic acq_done,
    input wire logic history_valid,
    input wire logic [dpsc_pkg::NUM_W-1:0] history_word,
    input wire logic step_trigger_pin,
    input wire logic step_direction_pin,
    output logic apll_lock_to_xo,
    output logic ref_qualified,
    output logic wide_bandwidth,
    output logic history_accumulate,
    output logic freq_lock_loss_flag,
    output logic phase_lock_loss_flag,
    output logic [dpsc_pkg::NUM_W-1:0] eff_feedback_numerator,
    output logic [dpsc_pkg::NUM_W-1:0] effective_apll_numerator,
    output logic ramp_done
);
    localparam int NUMW = dpsc_pkg::NUM_W;

    typedef struct packed {
        dpsc_pkg::dpsc_state_e st;
        logic [dpsc_pkg::CTRL_W-1:0] ctrl;
        logic [dpsc_pkg::DEV_W-1:0] dev;
        logic [NUMW-1:0] fbnum;
        logic [NUMW-1:0] dco_ofs;
        logic [NUMW-1:0] hofs;
        logic [NUMW-1:0] apnum;
        logic [NUMW-1:0] ramp_rem;
        logic [NUMW-1:0] ramp_acc;
        logic [dpsc_pkg::RSTEP_W-1:0] rstep;
        logic [dpsc_pkg::RPER_W-1:0] rper;
        logic [dpsc_pkg::RPER_W-1:0] rcnt;
        logic [NUMW-1:0] hold_word;
        logic rdone;
        logic fll;
        logic pll;
        logic apll_lk;
        logic trig_s1;
        logic trig_s2;
        logic trig_s3;
        logic dir_s1;
        logic dir_s2;
        logic [31:0] rdata;
    } dpsc_regs_s;

    dpsc_regs_s r_q;
    dpsc_regs_s r_d;

    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic step_req;
    logic [NUMW-1:0] dev_ext;
    logic [NUMW-1:0] rstep_ext;
    logic [NUMW-1:0] ramp_mag;
    logic [NUMW-1:0] ramp_inc;
    logic ramp_neg;
    logic [31:0] status_w;

    // ==========================================================
    // APB slave: zero wait states, error on unmapped address
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign addr_ok = (paddr <= dpsc_pkg::ADDR_DEV_LO) && (paddr[1:0] == 2'h0);
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = r_q.rdata;

    // trigger edge from the synchronised copy only
    assign step_req = r_q.trig_s2 && !r_q.trig_s3;
    assign dev_ext = {2'h0, r_q.dev};
    assign rstep_ext = {{(NUMW-dpsc_pkg::RSTEP_W){1'b0}}, r_q.rstep};
    assign ramp_neg = r_q.ramp_rem[NUMW-1];
    assign ramp_mag = ramp_neg ? (~r_q.ramp_rem + 40'h00_0000_0001) : r_q.ramp_rem;
    assign ramp_inc = (ramp_mag > rstep_ext) ? rstep_ext : ramp_mag;

    assign status_w = {22'h0, r_q.apll_lk, (r_q.st == dpsc_pkg::DPSC_ACQUIRE), r_q.rdone,
                       history_valid, r_q.pll, r_q.fll, r_q.st};

    always_comb begin
        r_d = r_q;
        r_d.trig_s1 = step_trigger_pin;
        r_d.trig_s2 = r_q.trig_s1;
        r_d.trig_s3 = r_q.trig_s2;
        r_d.dir_s1 = step_direction_pin;
        r_d.dir_s2 = r_q.dir_s1;
        // APLL follows the crystal once it is valid
        if (xo_valid) begin
            r_d.apll_lk = 1'b1;
        end
        // ======================================================
        // Operating state machine
        unique case (r_q.st)
            dpsc_pkg::DPSC_FREE_RUN: begin
                if (ref_valid && r_q.apll_lk) begin
                    r_d.st = dpsc_pkg::DPSC_ACQUIRE;
                end
            end
            dpsc_pkg::DPSC_ACQUIRE: begin
                if (!ref_valid) begin
                    r_d.st = dpsc_pkg::DPSC_FREE_RUN;
                end else if (acq_done) begin
                    r_d.st = dpsc_pkg::DPSC_LOCKED;
                end
            end
            dpsc_pkg::DPSC_LOCKED: begin
                if (!ref_valid) begin
                    // History gives a usable holdover only once valid
                    if (r_q.ctrl[dpsc_pkg::CTRL_HIST_EN] && history_valid) begin
                        r_d.st = dpsc_pkg::DPSC_HOLDOVER;
                        r_d.hold_word = history_word;
                    end else if (r_q.ctrl[dpsc_pkg::CTRL_HIST_EN]) begin
                        r_d.st = dpsc_pkg::DPSC_FREE_RUN;
                    end else begin
                        r_d.st = dpsc_pkg::DPSC_HOLDOVER;
                        r_d.hold_word = r_q.fbnum + r_q.hofs;
                    end
                    r_d.pll = 1'b1;
                end
            end
            dpsc_pkg::DPSC_HOLDOVER: begin
                if (ref_valid) begin
                    r_d.st = dpsc_pkg::DPSC_ACQUIRE;
                end
            end
        endcase
        // Lock flags follow detectors only with a reference selected
        if (r_q.st == dpsc_pkg::DPSC_ACQUIRE || r_q.st == dpsc_pkg::DPSC_LOCKED) begin
            if (r_d.st != dpsc_pkg::DPSC_HOLDOVER && r_d.st != dpsc_pkg::DPSC_FREE_RUN) begin
                r_d.fll = !freq_locked;
                r_d.pll = !phase_locked;
            end
        end
        // ======================================================
        // DPLL DCO steering
        if (r_q.ctrl[dpsc_pkg::CTRL_DCO_EN] && r_q.ctrl[dpsc_pkg::CTRL_PIN_EN] && step_req) begin
            r_d.dco_ofs = r_q.dir_s2 ? (r_q.dco_ofs - dev_ext)
                                     : (r_q.dco_ofs + dev_ext);
        end
        // ======================================================
        // APLL relative feed: one step per period until consumed
        if (r_q.ramp_rem != 40'h00_0000_0000) begin
            if (r_q.rcnt >= r_q.rper) begin
                r_d.rcnt = '0;
                r_d.ramp_acc = ramp_neg ? (r_q.ramp_acc - ramp_inc)
                                        : (r_q.ramp_acc + ramp_inc);
                r_d.ramp_rem = ramp_neg ? (r_q.ramp_rem + ramp_inc)
                                        : (r_q.ramp_rem - ramp_inc);
                if (ramp_inc == ramp_mag) begin
                    r_d.rdone = 1'b1;
                end
            end else begin
                r_d.rcnt = r_q.rcnt + 16'h0001;
            end
        end
        // ======================================================
        // Register writes
        if (wr_en && addr_ok) begin
            unique case (paddr)
                dpsc_pkg::ADDR_CTRL: begin
                    r_d.ctrl = pwdata[dpsc_pkg::CTRL_W-1:0];
                    if (!pwdata[dpsc_pkg::CTRL_DCO_EN]) begin
                        r_d.dco_ofs = '0;
                    end
                end
                dpsc_pkg::ADDR_STEP_CMD: begin
                    if (r_q.ctrl[dpsc_pkg::CTRL_DCO_EN]) begin
                        // Builds on any pin step of this cycle so neither is lost
                        r_d.dco_ofs = pwdata[0] ? (r_d.dco_ofs - dev_ext)
                                                : (r_d.dco_ofs + dev_ext);
                    end
                end
                dpsc_pkg::ADDR_DEV: begin
                    r_d.dev = {pwdata[5:0], r_q.dev[31:0]};
                end
                dpsc_pkg::ADDR_FBNUM_LO: begin
                    r_d.fbnum[31:0] = pwdata;
                end
                dpsc_pkg::ADDR_FBNUM_HI: begin
                    r_d.fbnum[39:32] = pwdata[7:0];
                end
                dpsc_pkg::ADDR_HOFS_LO: begin
                    r_d.hofs[31:0] = pwdata;
                end
                dpsc_pkg::ADDR_HOFS_HI: begin
                    // With history enabled, the upper half commits the word; a pending feed is dropped
                    r_d.hofs[39:32] = pwdata[7:0];
                    if (r_q.ctrl[dpsc_pkg::CTRL_HIST_EN]) begin
                        r_d.ramp_rem = {pwdata[7:0], r_q.hofs[31:0]};
                        r_d.rcnt = '0;
                        r_d.rdone = 1'b0;
                    end
                end
                dpsc_pkg::ADDR_APNUM_LO: begin
                    r_d.apnum[31:0] = pwdata;
                end
                dpsc_pkg::ADDR_APNUM_HI: begin
                    r_d.apnum[39:32] = pwdata[7:0];
                end
                dpsc_pkg::ADDR_RAMP: begin
                    r_d.rstep = pwdata[15:0];
                    r_d.rper = pwdata[31:16];
                end
                dpsc_pkg::ADDR_DEV_LO: begin
                    r_d.dev[31:0] = pwdata;
                end
                // Read-only offsets ignore writes
                default: begin
                end
            endcase
        end
        // Sub-word writes of the deviation: low word at its own offset
        if (wr_en && paddr == dpsc_pkg::ADDR_DEV) begin
            r_d.dev = {pwdata[5:0], r_q.dev[31:0]};
        end
        // ======================================================
        // Read data captured in setup so it stands in the access cycle
        r_d.rdata = dpsc_pkg::NOMAP_DATA;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                dpsc_pkg::ADDR_CTRL: r_d.rdata = {26'h0, r_q.ctrl};
                dpsc_pkg::ADDR_DEV: r_d.rdata = {26'h0, r_q.dev[37:32]};
                dpsc_pkg::ADDR_DEV_LO: r_d.rdata = r_q.dev[31:0];
                dpsc_pkg::ADDR_FBNUM_LO: r_d.rdata = r_q.fbnum[31:0];
                dpsc_pkg::ADDR_FBNUM_HI: r_d.rdata = {24'h0, r_q.fbnum[39:32]};
                dpsc_pkg::ADDR_HOFS_LO: r_d.rdata = r_q.hofs[31:0];
                dpsc_pkg::ADDR_HOFS_HI: r_d.rdata = {24'h0, r_q.hofs[39:32]};
                dpsc_pkg::ADDR_APNUM_LO: r_d.rdata = r_q.apnum[31:0];
                dpsc_pkg::ADDR_APNUM_HI: r_d.rdata = {24'h0, r_q.apnum[39:32]};
                dpsc_pkg::ADDR_EFFFB_LO: r_d.rdata = eff_feedback_numerator[31:0];
                dpsc_pkg::ADDR_EFFFB_HI: r_d.rdata = {24'h0, eff_feedback_numerator[39:32]};
                dpsc_pkg::ADDR_EFFAP_LO: r_d.rdata = effective_apll_numerator[31:0];
                dpsc_pkg::ADDR_EFFAP_HI: r_d.rdata = {24'h0, effective_apll_numerator[39:32]};
                dpsc_pkg::ADDR_STATUS: r_d.rdata = status_w;
                dpsc_pkg::ADDR_RAMP: r_d.rdata = {r_q.rper, r_q.rstep};
                default: r_d.rdata = dpsc_pkg::NOMAP_DATA;
            endcase
        end
        if (!resetn) begin
            r_d = '0;
            r_d.st = dpsc_pkg::DPSC_FREE_RUN;
            r_d.fll = 1'b1;
            r_d.pll = 1'b1;
            r_d.fbnum = dpsc_pkg::FBNUM_RST;
            r_d.apnum = dpsc_pkg::APNUM_RST;
            r_d.rstep = dpsc_pkg::RSTEP_RST;
            r_d.rper = dpsc_pkg::RPER_RST;
        end
    end

    always_ff @(posedge clk) begin
        r_q <= r_d;
    end

    // ==========================================================
    // Outputs
    assign apll_lock_to_xo = r_q.apll_lk;
    assign ref_qualified = (r_q.st != dpsc_pkg::DPSC_FREE_RUN);
    assign wide_bandwidth = (r_q.st == dpsc_pkg::DPSC_ACQUIRE);
    assign history_accumulate = r_q.ctrl[dpsc_pkg::CTRL_HIST_EN] && !r_q.fll
                                && (r_q.st == dpsc_pkg::DPSC_LOCKED);
    assign freq_lock_loss_flag = r_q.fll;
    assign phase_lock_loss_flag = r_q.pll;
    assign ramp_done = r_q.rdone;

    always_comb begin
        // closed loop steers the feedback numerator
        if (r_q.st == dpsc_pkg::DPSC_HOLDOVER) begin
            eff_feedback_numerator = r_q.hold_word;
        end else begin
            eff_feedback_numerator = r_q.fbnum + (r_q.ctrl[dpsc_pkg::CTRL_DCO_EN] ?
                                     r_q.dco_ofs : 40'h00_0000_0000);
        end
        // open loop steers the APLL numerator, signed offset
        if (r_q.ctrl[dpsc_pkg::CTRL_HIST_EN]) begin
            effective_apll_numerator = r_q.apnum + r_q.ramp_acc;
        end else begin
            effective_apll_numerator = r_q.apnum + r_q.hofs;
        end
    end

    // ==========================================================
    // Checks
    property p_acq_bw;
        @(posedge clk) disable iff (!resetn)
        (r_q.st == dpsc_pkg::DPSC_ACQUIRE) |-> wide_bandwidth;
    endproperty
    a_acq_bw: assert property (p_acq_bw) else $error("bandwidth not widened");

    property p_hold_pll;
        @(posedge clk) disable iff (!resetn)
        (r_q.st == dpsc_pkg::DPSC_HOLDOVER) |-> phase_lock_loss_flag;
    endproperty
    a_hold_pll: assert property (p_hold_pll) else $error("phase loss not set");

    property p_hold_fll;
        @(posedge clk) disable iff (!resetn)
        (r_q.st == dpsc_pkg::DPSC_HOLDOVER) ##1 (r_q.st == dpsc_pkg::DPSC_HOLDOVER)
        |-> $stable(freq_lock_loss_flag);
    endproperty
    a_hold_fll: assert property (p_hold_fll) else $error("freq flag moved");

    property p_noref_free;
        @(posedge clk) disable iff (!resetn)
        (r_q.st == dpsc_pkg::DPSC_LOCKED && !ref_valid && !history_valid)
        |=> (r_q.st != dpsc_pkg::DPSC_LOCKED);
    endproperty
    a_noref_free: assert property (p_noref_free) else $error("stayed locked");

    property p_pin_step;
        @(posedge clk) disable iff (!resetn)
        (step_req && r_q.ctrl[dpsc_pkg::CTRL_DCO_EN] && r_q.ctrl[dpsc_pkg::CTRL_PIN_EN]
         && !wr_en) |=> (r_q.dco_ofs != $past(r_q.dco_ofs)) || (r_q.dev == '0);
    endproperty
    a_pin_step: assert property (p_pin_step) else $error("pin step lost");

    property p_dco_clear;
        @(posedge clk) disable iff (!resetn)
        !r_q.ctrl[dpsc_pkg::CTRL_DCO_EN] |-> (r_q.dco_ofs == '0);
    endproperty
    a_dco_clear: assert property (p_dco_clear) else $error("offset kept");

    property p_step_pulse;
        @(posedge clk) disable iff (!resetn)
        step_req |=> !step_req;
    endproperty
    a_step_pulse: assert property (p_step_pulse) else $error("step not single");

    property p_ramp_done;
        @(posedge clk) disable iff (!resetn)
        r_q.rdone && r_q.ctrl[dpsc_pkg::CTRL_HIST_EN] |-> r_q.ramp_rem == '0;
    endproperty
    a_ramp_done: assert property (p_ramp_done) else $error("done early");

    c_hold: cover property (@(posedge clk) disable iff (!resetn)
        r_q.st == dpsc_pkg::DPSC_HOLDOVER);
    c_lock: cover property (@(posedge clk) disable iff (!resetn)
        r_q.st == dpsc_pkg::DPSC_LOCKED);
    c_ramp: cover property (@(posedge clk) disable iff (!resetn) $rose(r_q.rdone));
endmodule

// ---- testbench/dpsc_step_driver.sv ----
`timescale 1ns/1ps

module dpsc_step_driver (
    input wire logic clk,
    output logic trig,
    output logic dir
);
    // ==========================================================
    // Host step pins
    // High time well past the capture minimum of the sampling clock
    localparam int HIGH_CYC = 12;
    // Whole step period 240 ns keeps the step rate near 4 MHz
    localparam int PERIOD_CYC = 24;

    initial begin
        trig = 1'b0;
        dir = 1'b0;
    end

    // Direction settles one edge before the trigger rises
    task automatic pulse(input logic down);
        @(posedge clk);
        dir <= down;
        @(posedge clk);
        trig <= 1'b1;
        repeat (HIGH_CYC) @(posedge clk);
        trig <= 1'b0;
        repeat (PERIOD_CYC - HIGH_CYC) @(posedge clk);
    endtask
endmodule

// ---- testbench/dpsc_ctrl_tb_top.sv ----
`timescale 1ns/1ps

module dpsc_ctrl_tb_top;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic xo_valid, ref_valid, freq_locked, phase_locked, acq_done, history_valid;
    logic trig, dir, apll_lock_to_xo, ref_qualified, wide_bandwidth, history_accumulate;
    logic freq_lock_loss_flag, phase_lock_loss_flag, ramp_done, e;
    logic [39:0] history_word, eff_feedback_numerator, effective_apll_numerator;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic err;} dpsc_row_s;
    dpsc_row_s rows[8];

    dpsc_ctrl dpsc_ctrl_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xo_valid(xo_valid), .ref_valid(ref_valid),
        .freq_locked(freq_locked), .phase_locked(phase_locked), .acq_done(acq_done),
        .history_valid(history_valid), .history_word(history_word),
        .step_trigger_pin(trig), .step_direction_pin(dir), .apll_lock_to_xo(apll_lock_to_xo),
        .ref_qualified(ref_qualified), .wide_bandwidth(wide_bandwidth),
        .history_accumulate(history_accumulate), .freq_lock_loss_flag(freq_lock_loss_flag),
        .phase_lock_loss_flag(phase_lock_loss_flag),
        .eff_feedback_numerator(eff_feedback_numerator),
        .effective_apll_numerator(effective_apll_numerator), .ramp_done(ramp_done));

    dpsc_step_driver dpsc_step_driver_inst (.clk(clk), .trig(trig), .dir(dir));

    // ==========================================================
    // Clock, timeout, closing
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end

    task automatic results();
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [39:0] s, input logic [39:0] x);
        samples_checked++;
        if (s !== x) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask

    // ==========================================================
    // APB master: answer taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        rdy = 1'b0;
        while (rdy !== 1'b1) begin
            @(posedge clk);
            rdy = pready;
            r = prdata;
            e = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        // Let the write land before any output is looked at
        @(posedge clk);
    endtask

    task automatic st(input logic [3:0] x);
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, dpsc_pkg::ADDR_STATUS, 32'h0);
            if (r[3:0] === x) break;
        end
        chk("state", {36'h0, r[3:0]}, {36'h0, x});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; xo_valid = 1'b1; ref_valid = 1'b0;
        freq_locked = 1'b0; phase_locked = 1'b0; acq_done = 1'b0;
        history_valid = 1'b0; history_word = 40'h12_3456_789a;
        rows = '{'{dpsc_pkg::ADDR_DEV_LO, 32'h0000_0040, 32'h0000_0040, 1'b0},
            '{dpsc_pkg::ADDR_FBNUM_LO, 32'h0000_1000, 32'h0000_1000, 1'b0},
            '{dpsc_pkg::ADDR_FBNUM_HI, 32'h0000_0012, 32'h0000_0012, 1'b0},
            '{dpsc_pkg::ADDR_APNUM_LO, 32'h8000_0000, 32'h8000_0000, 1'b0},
            '{dpsc_pkg::ADDR_APNUM_HI, 32'h0000_0005, 32'h0000_0005, 1'b0},
            '{dpsc_pkg::ADDR_RAMP, 32'h0003_0100, 32'h0003_0100, 1'b0},
            '{8'h40, 32'h1234_5678, 32'h0, 1'b1},
            '{8'h02, 32'h1234_5678, 32'h0, 1'b1}};
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, dpsc_pkg::ADDR_STATUS, 32'h0);
        chk("reset status", {34'h0, r[5:0]}, 40'h31);
        apb(1'b0, dpsc_pkg::ADDR_RAMP, 32'h0);
        chk("reset ramp", {8'h0, r}, 40'h1);
        chk("xo lock", {39'h0, apll_lock_to_xo}, 40'h1);
        chk("unqualified", {39'h0, ref_qualified}, 40'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk("readback", {8'h0, r}, {8'h0, rows[i].x});
            chk("slave error", {39'h0, e}, {39'h0, rows[i].err});
        end
        // Acquisition, lock, history
        ref_valid <= 1'b1;
        st(dpsc_pkg::DPSC_ACQUIRE);
        chk("wide bw", {39'h0, wide_bandwidth}, 40'h1);
        acq_done <= 1'b1;
        st(dpsc_pkg::DPSC_LOCKED);
        chk("normal bw", {39'h0, wide_bandwidth}, 40'h0);
        freq_locked <= 1'b1;
        phase_locked <= 1'b1;
        wr(dpsc_pkg::ADDR_CTRL, 32'h39);
        repeat (4) @(posedge clk);
        chk("fll clear", {39'h0, freq_lock_loss_flag}, 40'h0);
        chk("history run", {39'h0, history_accumulate}, 40'h1);
        // DCO steering while locked, deviation 2^32 plus 0x40
        wr(dpsc_pkg::ADDR_DEV, 32'h1);
        wr(dpsc_pkg::ADDR_CTRL, 32'h3f);
        wr(dpsc_pkg::ADDR_STEP_CMD, 32'h0);
        chk("step up", eff_feedback_numerator, 40'h13_0000_1040);
        wr(dpsc_pkg::ADDR_STEP_CMD, 32'h1);
        wr(dpsc_pkg::ADDR_STEP_CMD, 32'h1);
        chk("step down", eff_feedback_numerator, 40'h11_0000_0fc0);
        dpsc_step_driver_inst.pulse(1'b0);
        chk("pin up", eff_feedback_numerator, 40'h12_0000_1000);
        dpsc_step_driver_inst.pulse(1'b1);
        chk("pin down", eff_feedback_numerator, 40'h11_0000_0fc0);
        wr(dpsc_pkg::ADDR_CTRL, 32'h3d);
        chk("dco off", eff_feedback_numerator, 40'h12_0000_1000);
        // Holdover with relative APLL feed
        history_valid <= 1'b1;
        ref_valid <= 1'b0;
        freq_locked <= 1'b0;
        phase_locked <= 1'b0;
        acq_done <= 1'b0;
        st(dpsc_pkg::DPSC_HOLDOVER);
        chk("pll flag", {39'h0, phase_lock_loss_flag}, 40'h1);
        chk("fll held", {39'h0, freq_lock_loss_flag}, 40'h0);
        chk("hold history", eff_feedback_numerator, 40'h12_3456_789a);
        wr(dpsc_pkg::ADDR_HOFS_LO, 32'h0000_0400);
        wr(dpsc_pkg::ADDR_HOFS_HI, 32'h0);
        chk("feeding", {39'h0, ramp_done}, 40'h0);
        for (int i = 0; i < 200 && ramp_done !== 1'b1; i++) @(posedge clk);
        chk("fed", effective_apll_numerator, 40'h05_8000_0400);
        ref_valid <= 1'b1;
        st(dpsc_pkg::DPSC_ACQUIRE);
        acq_done <= 1'b1;
        st(dpsc_pkg::DPSC_LOCKED);
        history_valid <= 1'b0;
        ref_valid <= 1'b0;
        st(dpsc_pkg::DPSC_FREE_RUN);
        // Absolute APLL offset, signed negative word
        wr(dpsc_pkg::ADDR_CTRL, 32'h3c);
        wr(dpsc_pkg::ADDR_HOFS_LO, 32'hffff_ff00);
        wr(dpsc_pkg::ADDR_HOFS_HI, 32'h0000_00ff);
        repeat (4) @(posedge clk);
        chk("absolute", effective_apll_numerator, 40'h05_7fff_ff00);
        // Holdover with history off: offset word on the feedback numerator
        ref_valid <= 1'b1;
        st(dpsc_pkg::DPSC_LOCKED);
        ref_valid <= 1'b0;
        st(dpsc_pkg::DPSC_HOLDOVER);
        chk("hold offset", eff_feedback_numerator, 40'h12_0000_0f00);
        results();
    end
endmodule
